// >>> temp_sensor_pkg.sv
// Shared constants, register map and types of the temperature sensor readout.
package temp_sensor_pkg;

   // ==========================================================
   // Clock and conversion timing
   // ==========================================================
   localparam int CLK_KHZ = 10000;
   localparam int FAST_CONV_MS = 6;
   localparam int CONV_MS = 240;
   localparam int SPS_CONV_MS = 60;
   localparam int SPS_PERIOD_MS = 1000;
   localparam int FAST_CONV_CYC = FAST_CONV_MS * CLK_KHZ;
   localparam int CONV_CYC = CONV_MS * CLK_KHZ;
   localparam int SPS_CONV_CYC = SPS_CONV_MS * CLK_KHZ;
   localparam int SPS_PERIOD_CYC = SPS_PERIOD_MS * CLK_KHZ;

   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [7:0] REG_TEMP_MSB = 8'h00;
   localparam logic [7:0] REG_TEMP_LSB = 8'h01;
   localparam logic [7:0] REG_STATUS = 8'h02;
   localparam logic [7:0] REG_CONFIG = 8'h03;
   localparam logic [7:0] REG_HIGH_MSB = 8'h04;
   localparam logic [7:0] REG_HIGH_LSB = 8'h05;
   localparam logic [7:0] REG_CRIT_MSB = 8'h08;
   localparam logic [7:0] REG_CRIT_LSB = 8'h09;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int CFG_RES_BIT = 7;
   localparam int CFG_MODE_LSB = 5;
   localparam int CFG_CRIT_INTR_BIT = 4;
   localparam int CFG_LIM_INTR_BIT = 3;
   localparam int STAT_BUSY_BIT = 7;
   localparam int STAT_LIM_BIT = 1;
   localparam int STAT_CRIT_BIT = 0;
   localparam int LOW_RES_PAD = 3;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [15:0] CRIT_RESET = 16'h4980;
   localparam logic [15:0] HIGH_RESET = 16'h2000;
   // Base of the serial bus address; the value is arbitrary.
   localparam logic [6:0] BUS_ADDR_BASE = 7'h2c;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      MODE_CONTINUOUS = 2'b00,
      MODE_ONE_SHOT = 2'b01,
      MODE_SPS = 2'b10,
      MODE_SHUTDOWN = 2'b11
   } op_mode_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

endpackage

// >>> alarm_channel.sv
// One alarm output with comparator and interrupt behaviour.
`timescale 1ns/10ps
`default_nettype none
module alarm_channel (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_update,
   input wire logic [15:0] i_temp,
   input wire logic [15:0] i_limit,
   input wire logic i_intr_mode,
   input wire logic i_clear,
   output logic o_alarm
);
   logic over;

   assign over = $signed(i_temp) > $signed(i_limit);

   // ==========================================================
   // Alarm state
   // ==========================================================
   // In interrupt behaviour a new excursion beats a clear in the same cycle.
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_alarm <= 1'b0;
      end else if (i_intr_mode) begin
         if (i_update && over) begin
            o_alarm <= 1'b1; // [RL13]
         end else if (i_clear) begin
            o_alarm <= 1'b0; // [RL13]
         end
      end else if (i_update) begin
         o_alarm <= over; // [RL13]
      end
   end

   comp_follow_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL7]
      (i_update && !i_intr_mode) |=> (o_alarm == $past(over)))
      else $error("comparator alarm does not follow the limit condition");

   intr_hold_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL13]
      (i_intr_mode && o_alarm && !i_clear) |=> o_alarm)
      else $error("interrupt alarm dropped without a clear");

   intr_set_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL6]
      (i_intr_mode && i_update && over) |=> o_alarm)
      else $error("interrupt alarm not set on excursion");
endmodule
`default_nettype wire

// >>> temp_sensor_core.sv
// Temperature result formatting, conversion scheduling, alarms and registers.
// Operation
// RL1: Power-up results are 13-bit, 0.0625 C steps.
// RL2: Config bit 7 selects 16-bit results.
// RL3: Results are two's complement, sign in bit 15.
// RL4: Two straps select four bus addresses.
// RL5: Critical alarm above limit, resets to 147 C.
// RL6: Limit alarm when temperature beyond host limit.
// RL7: Each alarm selectable comparator or interrupt.
// RL8: Shutdown mode stops conversions, powers down.
// RL9: Power-saving mode converts once per second.
// RL10: First conversion after power-up takes 6 ms.
// RL11: Normal conversions take 240 ms each.
// RL12: Saver mode converts 60 ms, idles rest.
// RL13: Comparator follows; interrupt latches until cleared.
// RL14: Resolution change applies from next conversion.
`timescale 1ns/10ps
`default_nettype none
module temp_sensor_core #(
   parameter int FAST_CYC = temp_sensor_pkg::FAST_CONV_CYC,
   parameter int CONV_LEN_CYC = temp_sensor_pkg::CONV_CYC,
   parameter int SPS_LEN_CYC = temp_sensor_pkg::SPS_CONV_CYC,
   parameter int SPS_PER_CYC = temp_sensor_pkg::SPS_PERIOD_CYC
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire temp_sensor_pkg::reg_req_t i_reg_req,
   output logic [7:0] o_reg_rdata,
   input wire logic [15:0] i_adc_data,
   output logic o_converter_power,
   output logic o_result_strobe,
   input wire logic i_addr_strap_0,
   input wire logic i_addr_strap_1,
   output logic [6:0] o_bus_address,
   output logic o_critical_alarm_out_oe,
   output logic o_limit_alarm_oe
);
   import temp_sensor_pkg::*;

   typedef enum {ST_CONV, ST_REST, ST_STOP} conv_state_t;

   conv_state_t state;
   conv_state_t next_state;
   logic [7:0] config_q;
   logic [15:0] limit [2];
   logic [15:0] temp_q;
   logic [31:0] cnt;
   logic [31:0] conv_len_q;
   logic [31:0] next_len;
   logic first_q;
   logic res_q;
   logic start;
   logic done;
   logic status_clear;
   logic [1:0] alarm;
   logic [1:0] intr_mode;
   logic [1:0] strap_q1;
   logic [1:0] strap_q2;
   op_mode_t mode;

   assign mode = op_mode_t'(config_q[CFG_MODE_LSB +: 2]);
   assign intr_mode = {config_q[CFG_LIM_INTR_BIT], config_q[CFG_CRIT_INTR_BIT]};
   assign done = (state == ST_CONV) && (cnt == conv_len_q - 32'h1);
   assign status_clear = i_reg_req.rd && (i_reg_req.addr == REG_STATUS);

   // ==========================================================
   // Conversion scheduling
   // ==========================================================
   always_comb begin
      next_state = state;
      start = 1'b0;
      if (mode == MODE_SHUTDOWN) begin
         next_state = ST_STOP; // [RL8]
      end else begin
         unique case (state)
            ST_CONV: begin
               if (done) begin
                  if (mode == MODE_SPS) begin
                     next_state = ST_REST; // [RL12]
                  end else if (mode == MODE_ONE_SHOT) begin
                     next_state = ST_STOP;
                  end else begin
                     start = 1'b1;
                  end
               end
            end
            ST_REST: begin
               if (mode != MODE_SPS || cnt == 32'(SPS_PER_CYC - 1)) begin
                  next_state = ST_CONV; // [RL9]
                  start = 1'b1;
               end
            end
            ST_STOP: begin
               next_state = ST_CONV;
               start = 1'b1;
            end
         endcase
      end
   end

   // The fast first conversion is loaded at reset, so a restart never repeats it.
   always_comb begin
      if (mode == MODE_SPS) begin
         next_len = 32'(SPS_LEN_CYC); // [RL12]
      end else begin
         next_len = 32'(CONV_LEN_CYC); // [RL11]
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= ST_CONV;
         cnt <= 32'h0;
         conv_len_q <= 32'(FAST_CYC); // [RL10]
      end else begin
         state <= next_state;
         if (start) begin
            cnt <= 32'h0;
            conv_len_q <= next_len;
         end else if (state != ST_STOP) begin
            cnt <= cnt + 32'h1;
         end
      end
   end

   // The resolution is sampled at conversion start so a result never mixes formats.
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         res_q <= 1'b0; // [RL1]
         first_q <= 1'b1;
      end else begin
         if (start) begin
            res_q <= config_q[CFG_RES_BIT]; // [RL14]
         end
         if (done || mode == MODE_SHUTDOWN) begin
            first_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Result formatting
   // ==========================================================
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         temp_q <= 16'h0;
         o_result_strobe <= 1'b0;
         o_converter_power <= 1'b1;
      end else begin
         o_result_strobe <= done;
         o_converter_power <= (next_state == ST_CONV); // [RL8]
         if (done) begin
            if (res_q) begin
               temp_q <= i_adc_data; // [RL2] [RL3]
            end else begin
               temp_q <= {i_adc_data[15:LOW_RES_PAD], LOW_RES_PAD'(0)}; // [RL1] [RL3]
            end
         end
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   // A finished one-shot falls back to shutdown; a host write in the same cycle wins.
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         config_q <= CONFIG_RESET;
         limit[0] <= CRIT_RESET; // [RL5]
         limit[1] <= HIGH_RESET;
      end else if (i_reg_req.wr) begin
         unique case (i_reg_req.addr)
            REG_CONFIG: config_q <= i_reg_req.wdata; // [RL2]
            REG_CRIT_MSB: limit[0][15:8] <= i_reg_req.wdata; // [RL5]
            REG_CRIT_LSB: limit[0][7:0] <= i_reg_req.wdata;
            REG_HIGH_MSB: limit[1][15:8] <= i_reg_req.wdata; // [RL6]
            REG_HIGH_LSB: limit[1][7:0] <= i_reg_req.wdata;
            default: ;
         endcase
      end else if (done && mode == MODE_ONE_SHOT) begin
         config_q[CFG_MODE_LSB +: 2] <= MODE_SHUTDOWN;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_reg_rdata <= 8'h0;
      end else if (i_reg_req.rd) begin
         unique case (i_reg_req.addr)
            REG_TEMP_MSB: o_reg_rdata <= temp_q[15:8];
            REG_TEMP_LSB: o_reg_rdata <= temp_q[7:0];
            REG_STATUS: begin
               o_reg_rdata <= 8'h0;
               o_reg_rdata[STAT_BUSY_BIT] <= (state == ST_CONV);
               o_reg_rdata[STAT_LIM_BIT] <= alarm[1];
               o_reg_rdata[STAT_CRIT_BIT] <= alarm[0];
            end
            REG_CONFIG: o_reg_rdata <= config_q;
            REG_CRIT_MSB: o_reg_rdata <= limit[0][15:8];
            REG_CRIT_LSB: o_reg_rdata <= limit[0][7:0];
            REG_HIGH_MSB: o_reg_rdata <= limit[1][15:8];
            REG_HIGH_LSB: o_reg_rdata <= limit[1][7:0];
            default: o_reg_rdata <= 8'h0;
         endcase
      end
   end

   // ==========================================================
   // Alarms
   // ==========================================================
   for (genvar gi = 0; gi < 2; gi++) begin : g_alarm
      alarm_channel u_alarm (
         .i_mclk(i_mclk),
         .i_resetn(i_resetn),
         .i_update(o_result_strobe),
         .i_temp(temp_q),
         .i_limit(limit[gi]),
         .i_intr_mode(intr_mode[gi]), // [RL7]
         .i_clear(status_clear), // [RL13]
         .o_alarm(alarm[gi])
      );
   end

   // Pin drive is one flop behind the alarm state so the ports stay registered.
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_critical_alarm_out_oe <= 1'b0;
         o_limit_alarm_oe <= 1'b0;
      end else begin
         o_critical_alarm_out_oe <= alarm[0]; // [RL5]
         o_limit_alarm_oe <= alarm[1]; // [RL6]
      end
   end

   // ==========================================================
   // Address straps
   // ==========================================================
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         strap_q1 <= 2'h0;
         strap_q2 <= 2'h0;
         o_bus_address <= BUS_ADDR_BASE;
      end else begin
         strap_q1 <= {i_addr_strap_1, i_addr_strap_0};
         strap_q2 <= strap_q1;
         o_bus_address <= {BUS_ADDR_BASE[6:2], strap_q2}; // [RL4]
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   low_res_fmt_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL1]
      (done && !res_q) |=> (temp_q[2:0] == 3'h0 && temp_q[15:3] == $past(i_adc_data[15:3])))
      else $error("low resolution result badly formatted");

   high_res_fmt_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL2]
      (done && res_q) |=> (temp_q == $past(i_adc_data)))
      else $error("high resolution result badly formatted");

   strap_addr_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL4]
      ##3 (o_bus_address[1:0] == $past({i_addr_strap_1, i_addr_strap_0}, 3)))
      else $error("bus address does not follow straps");

   shutdown_off_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL8]
      (mode == MODE_SHUTDOWN) |=> (!o_converter_power && state == ST_STOP))
      else $error("converter active in shutdown");

   fast_first_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL10]
      (done && first_q) |-> (cnt == 32'(FAST_CYC - 1)))
      else $error("first conversion length wrong");

   conv_len_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL11]
      (start && mode == MODE_CONTINUOUS) |=> (conv_len_q == 32'(CONV_LEN_CYC)))
      else $error("normal conversion length wrong");

   sps_len_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL12]
      (start && mode == MODE_SPS) |=> (conv_len_q == 32'(SPS_LEN_CYC)))
      else $error("saver conversion length wrong");

   sps_period_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL9]
      (state == ST_REST && start) |-> (cnt == 32'(SPS_PER_CYC - 1) || mode != MODE_SPS))
      else $error("saver period wrong");

   res_hold_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL14]
      (state == ST_CONV && !start) |=> $stable(res_q))
      else $error("resolution changed mid conversion");

   crit_pin_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL5]
      1'b1 |=> (o_critical_alarm_out_oe == $past(alarm[0])))
      else $error("critical pin does not follow alarm");

   lim_pin_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL6]
      1'b1 |=> (o_limit_alarm_oe == $past(alarm[1])))
      else $error("limit pin does not follow alarm");

   power_state_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL8]
      o_converter_power == (state == ST_CONV))
      else $error("converter power does not match conversion state");

   one_shot_end_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RL11]
      (done && mode == MODE_ONE_SHOT && !i_reg_req.wr) |=> (mode == MODE_SHUTDOWN))
      else $error("one-shot did not fall back to shutdown");
endmodule
`default_nettype wire

// >>> reg_host.sv
// Register host model that issues decoded register accesses to the sensor core.
`timescale 1ns/10ps
`default_nettype none
module reg_host (
   input wire logic i_mclk,
   output var temp_sensor_pkg::reg_req_t o_req,
   input wire logic [7:0] i_rdata
);
   import temp_sensor_pkg::*;
   // ==========================================================
   // Access tasks
   // ==========================================================
   // Idle fields carry inverted values, so a core that ignores the strobes is caught.
   initial o_req = '0;
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_mclk);
      o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge i_mclk);
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_mclk);
      o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge i_mclk);
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench of the temperature sensor core.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import temp_sensor_pkg::*;
   // ==========================================================
   // Signals and instances
   // ==========================================================
   localparam int FAST = 6;
   localparam int CONV = 24;
   localparam int SLEN = 6;
   localparam int SPER = 100;
   logic mclk;
   logic resetn;
   reg_req_t req;
   logic [7:0] rdata;
   logic [15:0] adc;
   logic power;
   logic strobe;
   logic s0;
   logic s1;
   logic [6:0] bus_addr;
   logic crit_oe;
   logic lim_oe;
   int fail_count;
   int cmp_count;
   int n;
   int p;
   logic [15:0] v;
   logic [7:0] b;
   temp_sensor_core #(.FAST_CYC(FAST), .CONV_LEN_CYC(CONV), .SPS_LEN_CYC(SLEN),
      .SPS_PER_CYC(SPER)) dut (.i_mclk(mclk), .i_resetn(resetn), .i_reg_req(req),
      .o_reg_rdata(rdata), .i_adc_data(adc), .o_converter_power(power),
      .o_result_strobe(strobe), .i_addr_strap_0(s0), .i_addr_strap_1(s1),
      .o_bus_address(bus_addr), .o_critical_alarm_out_oe(crit_oe),
      .o_limit_alarm_oe(lim_oe));
   reg_host host (.i_mclk(mclk), .o_req(req), .i_rdata(rdata));
   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_strobe(output int cyc, output int pwr);
      cyc = 0;
      pwr = 0;
      do begin
         @(negedge mclk);
         cyc++;
         if (power === 1'b1) pwr++;
      end while (strobe !== 1'b1 && cyc < 300);
      if (cyc >= 300) fail_count++;
   endtask
   task automatic read16(input logic [7:0] a, output logic [15:0] val);
      logic [7:0] hi;
      logic [7:0] lo;
      host.reg_read(a, hi);
      host.reg_read(a + 8'h01, lo);
      val = {hi, lo};
   endtask
   // The first strobe already carries the new sample; wait for two, then two cycles for alarm and pin.
   task automatic settle(input logic [15:0] val);
      adc = val;
      wait_strobe(n, p);
      wait_strobe(n, p);
      repeat (2) @(negedge mclk);
   endtask
   task automatic conclude;
      $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog and tests
   // ==========================================================
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      conclude();
   end
   initial begin
      fail_count = 0;
      cmp_count = 0;
      resetn = 1'b0;
      adc = 16'h0c8f;
      s0 = 1'b0;
      s1 = 1'b0;
      repeat (4) @(negedge mclk);
      resetn = 1'b1;
      wait_strobe(n, p);
      check("first conv", 16'(FAST), 16'(n));
      wait_strobe(n, p);
      check("second conv", 16'(CONV), 16'(n));
      read16(REG_TEMP_MSB, v);
      check("temp 13 bit", 16'h0c88, v);
      host.reg_read(REG_CONFIG, b);
      check("config reset", {8'h00, CONFIG_RESET}, {8'h00, b});
      read16(REG_CRIT_MSB, v);
      check("crit reset", 16'(147 * 128), v);
      read16(REG_HIGH_MSB, v);
      check("high reset", HIGH_RESET, v);
      host.reg_read(8'h0f, b);
      check("unmapped", 16'h0, {8'h00, b});
      host.reg_write(REG_TEMP_MSB, 8'h55);
      host.reg_read(REG_TEMP_MSB, b);
      check("temp read only", 16'h000c, {8'h00, b});
      for (int i = 0; i < 4; i++) begin
         s0 = i[0];
         s1 = i[1];
         repeat (4) @(negedge mclk);
         check("bus addr", {9'h0, BUS_ADDR_BASE[6:2], i[1], i[0]}, {9'h0, bus_addr});
      end
      wait_strobe(n, p);
      wait_strobe(n, p);
      check("conv cycles", 16'(CONV), 16'(n));
      adc = 16'hf00f;
      wait_strobe(n, p);
      host.reg_write(REG_CONFIG, 8'h80);
      wait_strobe(n, p);
      read16(REG_TEMP_MSB, v);
      check("temp before switch", 16'hf008, v);
      wait_strobe(n, p);
      read16(REG_TEMP_MSB, v);
      check("temp 16 bit", 16'hf00f, v);
      check("crit negative", 16'h0, {15'h0, crit_oe});
      host.reg_write(REG_HIGH_MSB, 8'h01);
      host.reg_write(REG_HIGH_LSB, 8'h00);
      settle(16'h4981);
      check("crit above", 16'h1, {15'h0, crit_oe});
      check("lim above", 16'h1, {15'h0, lim_oe});
      settle(16'h4980);
      check("crit at limit", 16'h0, {15'h0, crit_oe});
      check("lim still above", 16'h1, {15'h0, lim_oe});
      settle(16'h0100);
      check("lim at limit", 16'h0, {15'h0, lim_oe});
      host.reg_write(REG_CONFIG, 8'h98);
      settle(16'h4981);
      check("crit intr set", 16'h1, {15'h0, crit_oe});
      check("lim intr set", 16'h1, {15'h0, lim_oe});
      settle(16'h0000);
      check("crit latched", 16'h1, {15'h0, crit_oe});
      check("lim latched", 16'h1, {15'h0, lim_oe});
      host.reg_read(REG_STATUS, b);
      check("status alarms", 16'h3, {14'h0, b[1:0]});
      check("status busy", 16'h1, {15'h0, b[7]});
      repeat (2) @(negedge mclk);
      check("crit cleared", 16'h0, {15'h0, crit_oe});
      check("lim cleared", 16'h0, {15'h0, lim_oe});
      host.reg_write(REG_CONFIG, 8'h60);
      repeat (3) @(negedge mclk);
      check("shutdown power", 16'h0, {15'h0, power});
      p = 0;
      repeat (60) begin
         @(negedge mclk);
         if (strobe === 1'b1) p++;
      end
      check("shutdown strobes", 16'h0, 16'(p));
      host.reg_write(REG_CONFIG, 8'h20);
      wait_strobe(n, p);
      check("one-shot conv", 16'h1, {15'h0, n >= CONV - 1 && n <= CONV + 2});
      repeat (2) @(negedge mclk);
      host.reg_read(REG_CONFIG, b);
      check("one-shot ends", 16'h0060, {8'h00, b});
      host.reg_write(REG_CONFIG, 8'h40);
      wait_strobe(n, p);
      wait_strobe(n, p);
      wait_strobe(n, p);
      check("saver period", 16'(SPER), 16'(n));
      check("saver active", 16'(SLEN), 16'(p));
      conclude();
   end
endmodule
`default_nettype wire
